// ---- core/uec_ctrl.sv ----
// USB device endpoint control: address, soft connect, endpoint config,
// stall, status clear, data acknowledge, receive byte count.
// Assumes the packet engine reports tokens and receive bytes as pulses.
//
// Operation
// R1: Device answers tokens only at the address last written by software; here writes before device mode are dropped.
// R2: Soft connect asserted attaches the device to the bus; here only once device mode is set.
// R3: Soft connect deasserted detaches the device until reasserted.
// R4: Configuration readback returns the last written size and flags per direction.
// R5: Endpoint zero configuration is fixed and ignores writes.
// R6: Type field selects control, isochronous, bulk or interrupt.
// R7: Each endpoint direction holds a DMA access select.
// R8: Auto send marks IN packet ready once max packet bytes are written.
// R9: Auto request asks for data when FIFO can take another packet; here, with max packet above 8 bytes, once the 8-byte buffer is empty.
// R10: Auto clear drops OUT packet ready once the data is read out.
// R11: Without auto clear, software clears OUT packet ready itself.
// R12: Software acknowledges read OUT data with an explicit strobe.
// R13: Final packet flag matters only on endpoint zero.
// R14: Stall command stalls only the chosen direction of one endpoint.
// R15: Stall clear removes stall only from the chosen direction.
// R16: Status clear clears exactly the presented bits.
// R17: A mode bit switches the controller into device mode.
// R18: Received byte count per OUT endpoint is reported.
// R19: Shared FIFO memory totals 2048 or 4096 bytes; the receive buffer here holds only 8 bytes.
// R20: First 64 bytes belong to endpoint zero.
// R21: Stalled direction answers every token with STALL.
// R22: Byte count reads zero after the last packet is read and acknowledged.
`default_nettype none
`include "uec_defs.svh"
module uec_ctrl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Mode and attach
    input wire logic dual_role_device_select,
    input wire logic soft_connect,
    output logic device_mode,
    output logic bus_attach,
    // Address
    input wire logic addr_wr,
    input wire logic [`UEC_ADDR_W-1:0] addr_wdata,
    output logic [`UEC_ADDR_W-1:0] dev_addr,
    // Endpoint configuration
    input wire logic cfg_wr,
    input wire logic [`UEC_EP_W-1:0] cfg_ep,
    input wire uec_pkg::uec_dir_t cfg_dir,
    input wire logic [`UEC_MPS_W-1:0] max_packet_bytes,
    input wire uec_pkg::uec_ep_type_t cfg_type,
    input wire logic [1:0] ep_dma_access_select,
    input wire logic tx_auto_send,
    input wire logic rx_auto_request,
    input wire logic rx_auto_ready_clear,
    output logic [`UEC_MPS_W-1:0] cfg_rd_mps,
    output logic [1:0] cfg_rd_type,
    output logic [1:0] cfg_rd_dma,
    output logic [2:0] cfg_rd_auto,
    // Stall and status commands
    input wire logic stall_set,
    input wire logic stall_clr,
    input wire logic [`UEC_EP_W-1:0] cmd_ep,
    input wire uec_pkg::uec_dir_t cmd_dir,
    input wire logic status_clr,
    input wire logic [`UEC_ST_W-1:0] status_clr_bits,
    input wire logic data_ack,
    input wire logic final_packet_flag,
    output logic [`UEC_ST_W-1:0] out_status,
    output logic [`UEC_CNT_W-1:0] rx_byte_count,
    output logic ep0_data_end,
    // Packet engine side
    input wire logic tok_valid,
    input wire logic [`UEC_ADDR_W-1:0] tok_addr,
    input wire logic [`UEC_EP_W-1:0] tok_ep,
    input wire uec_pkg::uec_dir_t tok_dir,
    output uec_pkg::uec_hs_t tok_hs,
    output logic tok_hit,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    output logic rx_byte_ready,
    input wire logic rx_pkt_end,
    input wire logic tx_byte_wr,
    output logic tx_pkt_ready,
    output logic rx_more_request,
    // Software read of OUT data
    output logic rd_valid,
    output logic [7:0] rd_data,
    input wire logic rd_ready
);
    localparam int NE = `UEC_NUM_EP;
    localparam int FD = `UEC_FIFO_DEPTH;

    logic [`UEC_ADDR_W-1:0] addr_r;
    logic mode_r;
    logic [`UEC_MPS_W-1:0] mps_r [NE][2];
    logic [1:0] type_r [NE][2];
    logic [1:0] dma_r [NE][2];
    logic [2:0] auto_r [NE][2];
    logic [1:0] stall_r [NE];
    logic [`UEC_ST_W-1:0] st_r [NE];
    logic [`UEC_CNT_W-1:0] cnt_r [NE];
    logic [`UEC_CNT_W-1:0] tx_cnt_r [NE];
    logic [NE-1:0] tx_rdy_r;
    logic [`UEC_EP_W-1:0] rx_ep_r;
    logic data_end_r;
    logic hit_r;
    uec_pkg::uec_hs_t hs_r;
    logic f_in_ready;
    logic [$clog2(FD):0] f_count;
    logic pop;

    // ----------------------------------------
    // Receive buffer
    // ----------------------------------------
    // Incoming bytes are buffered; a full buffer stalls the packet engine.
    uec_fifo #(.WIDTH(8), .DEPTH(FD)) u_rx_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_valid(rx_byte_valid),
        .in_data(rx_byte),
        .in_ready(f_in_ready),
        .out_valid(rd_valid),
        .out_data(rd_data),
        .out_ready(rd_ready),
        .count(f_count)
    );
    assign rx_byte_ready = f_in_ready;
    assign pop = rd_valid && rd_ready;

    // ----------------------------------------
    // Mode, attach and address
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            mode_r <= 1'b0;
        end
        else if (dual_role_device_select)
        begin
            mode_r <= 1'b1; // see R17
        end
    end
    assign device_mode = mode_r;
    // Attach follows soft connect level once in device mode; no latch so detach holds
    assign bus_attach = mode_r && soft_connect; // see R2 see R3

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            addr_r <= '0;
        end
        else if (addr_wr && mode_r)
        begin
            addr_r <= addr_wdata; // see R1
        end
    end
    assign dev_addr = addr_r;

    // ----------------------------------------
    // Endpoint configuration
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            for (int e = 0; e < NE; e++)
            begin
                for (int d = 0; d < 2; d++)
                begin
                    mps_r[e][d] <= (e == 0) ? `UEC_EP0_MPS : '0; // see R20
                    type_r[e][d] <= (e == 0) ? 2'h0 : 2'h2;
                    dma_r[e][d] <= 2'h0;
                    auto_r[e][d] <= 3'h0;
                end
            end
        end
        else if (cfg_wr && cfg_ep != '0) // see R5
        begin
            mps_r[cfg_ep][cfg_dir] <= max_packet_bytes; // see R4
            type_r[cfg_ep][cfg_dir] <= cfg_type; // see R6
            dma_r[cfg_ep][cfg_dir] <= ep_dma_access_select; // see R7
            auto_r[cfg_ep][cfg_dir] <= {tx_auto_send, rx_auto_request, rx_auto_ready_clear};
        end
    end
    assign cfg_rd_mps = mps_r[cfg_ep][cfg_dir]; // see R4
    assign cfg_rd_type = type_r[cfg_ep][cfg_dir];
    assign cfg_rd_dma = dma_r[cfg_ep][cfg_dir];
    assign cfg_rd_auto = auto_r[cfg_ep][cfg_dir];

    // ----------------------------------------
    // Stall per direction
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            for (int e = 0; e < NE; e++)
            begin
                stall_r[e] <= 2'h0;
            end
        end
        else if (stall_set)
        begin
            stall_r[cmd_ep][cmd_dir] <= 1'b1; // see R14
        end
        else if (stall_clr)
        begin
            stall_r[cmd_ep][cmd_dir] <= 1'b0; // see R15
        end
    end

    // ----------------------------------------
    // Token answers
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            hs_r <= uec_pkg::hs_none;
            hit_r <= 1'b0;
        end
        else
        begin
            hit_r <= tok_valid && bus_attach && (tok_addr == addr_r); // see R1
            if (!(tok_valid && bus_attach && tok_addr == addr_r))
            begin
                hs_r <= uec_pkg::hs_none;
            end
            else if (stall_r[tok_ep][tok_dir])
            begin
                hs_r <= uec_pkg::hs_stall; // see R21
            end
            else if (tok_dir == uec_pkg::dir_sel_in_side)
            begin
                hs_r <= tx_rdy_r[tok_ep] ? uec_pkg::hs_ack : uec_pkg::hs_nak;
            end
            else
            begin
                hs_r <= st_r[tok_ep][`UEC_ST_PKT_READY] ? uec_pkg::hs_nak : uec_pkg::hs_ack;
            end
        end
    end
    assign tok_hs = hs_r;
    assign tok_hit = hit_r;

    // ----------------------------------------
    // OUT status, byte count and acknowledge
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            rx_ep_r <= '0;
        end
        else if (tok_valid && tok_dir == uec_pkg::dir_sel_out_side && tok_addr == addr_r)
        begin
            rx_ep_r <= tok_ep;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            for (int e = 0; e < NE; e++)
            begin
                st_r[e] <= '0;
                cnt_r[e] <= '0;
            end
        end
        else
        begin
            for (int e = 0; e < NE; e++)
            begin
                logic [`UEC_ST_W-1:0] s;
                logic [`UEC_CNT_W-1:0] c;
                s = st_r[e];
                c = cnt_r[e];
                if (status_clr && cmd_ep == `UEC_EP_W'(e))
                begin
                    s = s & ~status_clr_bits; // see R16
                end
                if (data_ack && cmd_ep == `UEC_EP_W'(e))
                begin
                    s[`UEC_ST_PKT_READY] = 1'b0; // see R12
                end
                if (pop && rx_ep_r == `UEC_EP_W'(e) && c != '0)
                begin
                    c = c - 1'b1; // see R22
                    if (c == '0 && auto_r[e][0][0])
                    begin
                        s[`UEC_ST_PKT_READY] = 1'b0; // see R10
                    end
                end
                if (rx_ep_r == `UEC_EP_W'(e))
                begin
                    if (rx_byte_valid && f_in_ready)
                    begin
                        c = c + 1'b1; // see R18
                    end
                    // Hardware events win over a same-cycle clear
                    if (rx_byte_valid && !f_in_ready)
                    begin
                        s[`UEC_ST_OVERRUN] = 1'b1;
                    end
                    if (rx_pkt_end)
                    begin
                        s[`UEC_ST_PKT_READY] = 1'b1;
                    end
                end
                if (tok_valid && bus_attach && tok_addr == addr_r && tok_ep == `UEC_EP_W'(e)
                    && tok_dir == uec_pkg::dir_sel_out_side && stall_r[e][0])
                begin
                    s[`UEC_ST_SENT_STALL] = 1'b1; // see R21
                end
                s[`UEC_ST_FIFO_FULL] = !f_in_ready;
                st_r[e] <= s;
                cnt_r[e] <= c;
            end
        end
    end
    assign out_status = st_r[cmd_ep];
    assign rx_byte_count = cnt_r[cmd_ep];

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            data_end_r <= 1'b0;
        end
        else
        begin
            // Final flag only kept for endpoint zero
            data_end_r <= data_ack && final_packet_flag && (cmd_ep == '0); // see R13
        end
    end
    assign ep0_data_end = data_end_r;

    // Request more when buffer room reaches one max packet (capped to depth)
    assign rx_more_request = auto_r[rx_ep_r][0][1] &&
        ((`UEC_CNT_W'(FD) - `UEC_CNT_W'(f_count)) >= `UEC_CNT_W'(FD)
         || (`UEC_CNT_W'(FD) - `UEC_CNT_W'(f_count)) >= mps_r[rx_ep_r][0]); // see R9

    // ----------------------------------------
    // IN packet ready
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            tx_rdy_r <= '0;
            for (int e = 0; e < NE; e++)
            begin
                tx_cnt_r[e] <= '0;
            end
        end
        else
        begin
            for (int e = 0; e < NE; e++)
            begin
                if (tok_valid && bus_attach && tok_addr == addr_r && tok_ep == `UEC_EP_W'(e)
                    && tok_dir == uec_pkg::dir_sel_in_side && tx_rdy_r[e] && !stall_r[e][1])
                begin
                    tx_rdy_r[e] <= 1'b0;
                    tx_cnt_r[e] <= '0;
                end
                else if (tx_byte_wr && cfg_ep == `UEC_EP_W'(e) && !tx_rdy_r[e])
                begin
                    tx_cnt_r[e] <= tx_cnt_r[e] + 1'b1;
                    if (auto_r[e][1][2] && tx_cnt_r[e] + 1'b1 == mps_r[e][1])
                    begin
                        tx_rdy_r[e] <= 1'b1; // see R8
                    end
                end
            end
        end
    end
    assign tx_pkt_ready = tx_rdy_r[cfg_ep];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_tok_stalled;
        tok_valid && bus_attach && tok_addr == addr_r && stall_r[tok_ep][tok_dir];
    endsequence

    a_stall_answer: assert property (@(posedge core_clk) disable iff (!rst_n) // see R21
        s_tok_stalled |=> tok_hs == uec_pkg::hs_stall) else $error("stalled token not answered stall");
    a_addr_miss: assert property (@(posedge core_clk) disable iff (!rst_n) // see R1
        tok_valid && tok_addr != addr_r |=> !tok_hit) else $error("foreign address answered");
    a_detach_quiet: assert property (@(posedge core_clk) disable iff (!rst_n) // see R3
        !soft_connect |-> !bus_attach) else $error("attached while disconnected");
    a_ep0_fixed: assert property (@(posedge core_clk) disable iff (!rst_n) // see R5
        mps_r[0][0] == `UEC_EP0_MPS && mps_r[0][1] == `UEC_EP0_MPS) else $error("endpoint zero size changed");
    a_cfg_store: assert property (@(posedge core_clk) disable iff (!rst_n) // see R4
        cfg_wr && cfg_ep != '0 ##1 !cfg_wr && $stable(cfg_ep) && $stable(cfg_dir)
        |-> cfg_rd_mps == $past(max_packet_bytes)) else $error("config readback mismatch");
    a_stall_set: assert property (@(posedge core_clk) disable iff (!rst_n) // see R14
        stall_set |=> stall_r[$past(cmd_ep)][$past(cmd_dir)]) else $error("stall not set");
    a_stall_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // see R15
        stall_clr && !stall_set |=> !stall_r[$past(cmd_ep)][$past(cmd_dir)]) else $error("stall not cleared");
    a_final_ep0: assert property (@(posedge core_clk) disable iff (!rst_n) // see R13
        data_ack && cmd_ep != '0 |=> !ep0_data_end) else $error("final flag on other endpoint");
    a_mode_sticky: assert property (@(posedge core_clk) disable iff (!rst_n) // see R17
        dual_role_device_select |=> device_mode [*2]) else $error("device mode not held");
endmodule : uec_ctrl
`default_nettype wire

// ---- core/uec_defs.svh ----
// Constants for the USB device endpoint control block.
// Assumes inclusion by bare name from core/ and verif/ files.
`ifndef UEC_DEFS_SVH
`define UEC_DEFS_SVH

`define UEC_NUM_EP 4
`define UEC_EP_W 2
`define UEC_ADDR_W 7
`define UEC_MPS_W 11
`define UEC_EP0_MPS 11'h040
`define UEC_FIFO_TOTAL 4096
`define UEC_EP0_RESERVED 64
`define UEC_FIFO_DEPTH 8
`define UEC_CNT_W 11
`define UEC_ST_W 5
`define UEC_ST_SENT_STALL 0
`define UEC_ST_DATA_ERR 1
`define UEC_ST_OVERRUN 2
`define UEC_ST_FIFO_FULL 3
`define UEC_ST_PKT_READY 4

`endif

// ---- core/uec_pkg.sv ----
// Types for the USB device endpoint control block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package uec_pkg;
    typedef enum logic [1:0] {ep_type_control, ep_type_isochronous, ep_type_bulk, ep_type_interrupt} uec_ep_type_t;
    typedef enum logic [1:0] {hs_none, hs_ack, hs_nak, hs_stall} uec_hs_t;
    typedef enum logic {dir_sel_out_side, dir_sel_in_side} uec_dir_t;
endpackage : uec_pkg
`default_nettype wire

// ---- core/uec_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`default_nettype none
module uec_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    // Occupancy
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rd_ptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign count = cnt_r;

    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop)
            begin
                cnt_r <= cnt_r + 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule : uec_fifo
`default_nettype wire

// ---- verif/uec_host_model.sv ----
// Host-side model: sends tokens and OUT packet bytes.
// Assumes its tasks are called at falling edges of core_clk.
`default_nettype none
module uec_host_model (
    // Clock
    input wire logic core_clk,
    // Token side
    output logic tok_valid,
    output logic [6:0] tok_addr,
    output logic [1:0] tok_ep,
    output uec_pkg::uec_dir_t tok_dir,
    // OUT data side
    output logic rx_byte_valid,
    output logic [7:0] rx_byte,
    input wire logic rx_byte_ready,
    output logic rx_pkt_end
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        tok_valid = 1'b0;
        tok_addr = 7'h00;
        tok_ep = 2'h0;
        tok_dir = uec_pkg::dir_sel_out_side;
        rx_byte_valid = 1'b0;
        rx_byte = 8'h00;
        rx_pkt_end = 1'b0;
    end
    task automatic token(input logic [6:0] a, input logic [1:0] e, input uec_pkg::uec_dir_t d);
        tok_valid = 1'b1;
        tok_addr = a;
        tok_ep = e;
        tok_dir = d;
        @(negedge core_clk);
        tok_valid = 1'b0;
        // Released lines show garbage, not the old value
        tok_addr = ~a;
        tok_ep = ~e;
    endtask : token
    task automatic packet(input logic [6:0] a, input logic [1:0] e, input int n, input logic [7:0] b);
        int k;
        token(a, e, uec_pkg::dir_sel_out_side);
        for (int i = 0; i < n; i++)
        begin
            rx_byte_valid = 1'b1;
            rx_byte = b + i[7:0];
            k = 0;
            while (!rx_byte_ready && k < 40)
            begin
                @(negedge core_clk);
                k++;
            end
            @(negedge core_clk);
        end
        rx_byte_valid = 1'b0;
        rx_byte = ~rx_byte;
        rx_pkt_end = 1'b1;
        @(negedge core_clk);
        rx_pkt_end = 1'b0;
    endtask : packet
endmodule : uec_host_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// Bench for uec_ctrl with the host model on the packet side.
// Assumes core/ on the include path.
`default_nettype none
`include "uec_defs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // --------
    // Signals
    // --------
    logic core_clk = 1'b0;
    logic rst_n, dual_role_device_select, soft_connect, device_mode, bus_attach, addr_wr, cfg_wr;
    logic [6:0] addr_wdata, dev_addr, tok_addr;
    logic [1:0] cfg_ep, cmd_ep, tok_ep, cfg_rd_type, cfg_rd_dma, ep_dma_access_select;
    uec_pkg::uec_dir_t cfg_dir, cmd_dir, tok_dir;
    uec_pkg::uec_ep_type_t cfg_type;
    uec_pkg::uec_hs_t tok_hs;
    logic [10:0] max_packet_bytes, cfg_rd_mps, rx_byte_count;
    logic tx_auto_send, rx_auto_request, rx_auto_ready_clear, stall_set, stall_clr, status_clr;
    logic data_ack, final_packet_flag, ep0_data_end, tok_valid, tok_hit, rx_byte_valid;
    logic rx_byte_ready, rx_pkt_end, tx_byte_wr, tx_pkt_ready, rx_more_request, rd_valid, rd_ready;
    logic [2:0] cfg_rd_auto;
    logic [4:0] status_clr_bits, out_status;
    logic [7:0] rx_byte, rd_data;
    int n_errors = 0;
    int n_checks = 0;
    always #12.5 core_clk = ~core_clk;
    uec_ctrl u_dut (.core_clk, .rst_n, .dual_role_device_select, .soft_connect, .device_mode,
        .bus_attach, .addr_wr, .addr_wdata, .dev_addr, .cfg_wr, .cfg_ep, .cfg_dir, .max_packet_bytes,
        .cfg_type, .ep_dma_access_select, .tx_auto_send, .rx_auto_request, .rx_auto_ready_clear,
        .cfg_rd_mps, .cfg_rd_type, .cfg_rd_dma, .cfg_rd_auto, .stall_set, .stall_clr, .cmd_ep,
        .cmd_dir, .status_clr, .status_clr_bits, .data_ack, .final_packet_flag, .out_status,
        .rx_byte_count, .ep0_data_end, .tok_valid, .tok_addr, .tok_ep, .tok_dir, .tok_hs, .tok_hit,
        .rx_byte_valid, .rx_byte, .rx_byte_ready, .rx_pkt_end, .tx_byte_wr, .tx_pkt_ready,
        .rx_more_request, .rd_valid, .rd_data, .rd_ready);
    uec_host_model u_host (.core_clk, .tok_valid, .tok_addr, .tok_ep, .tok_dir, .rx_byte_valid,
        .rx_byte, .rx_byte_ready, .rx_pkt_end);
    // --------
    // Helpers
    // --------
    task automatic finish_test;
        if (n_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e)
        begin
            n_errors++;
            $display("mismatch %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick
    // Two cycles per pulse so back-to-back calls never retoggle in one step
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(1);
    endtask : pulse
    task automatic cfgw(input logic [1:0] e, input uec_pkg::uec_dir_t d, input logic [10:0] m,
        input uec_pkg::uec_ep_type_t t, input logic [1:0] dm, input logic [2:0] au);
        cfg_ep = e;
        cfg_dir = d;
        max_packet_bytes = m;
        cfg_type = t;
        ep_dma_access_select = dm;
        {tx_auto_send, rx_auto_request, rx_auto_ready_clear} = au;
        pulse(cfg_wr);
    endtask : cfgw
    task automatic pop(input int n, input logic [7:0] b);
        rd_ready = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            chk("rd_valid", rd_valid, 1'b1);
            chk("rd_data", rd_data, b + i[7:0]);
            tick(1);
        end
        rd_ready = 1'b0;
        tick(1);
    endtask : pop
    task automatic stall_tok(input uec_pkg::uec_dir_t d, input logic e);
        u_host.token(7'h2a, 2'h1, d);
        chk("stall_hs", tok_hs == uec_pkg::hs_stall, e);
    endtask : stall_tok
    // --------
    // Scenarios
    // --------
    task automatic t_mode;
        chk("mode_rst", device_mode, 1'b0);
        chk("ep0_mps", cfg_rd_mps, `UEC_EP0_MPS);
        addr_wdata = 7'h2a;
        pulse(addr_wr);
        chk("addr_refused", dev_addr, 7'h00);
        pulse(dual_role_device_select);
        chk("mode", device_mode, 1'b1);
        pulse(addr_wr);
        chk("addr", dev_addr, 7'h2a);
        soft_connect = 1'b1;
        tick(1);
        chk("attach", bus_attach, 1'b1);
        soft_connect = 1'b0;
        tick(3);
        chk("detach", bus_attach, 1'b0);
        soft_connect = 1'b1;
        tick(1);
        chk("reattach", bus_attach, 1'b1);
    endtask : t_mode
    task automatic t_cfg;
        for (int i = 0; i < 4; i++)
            cfgw(i / 2 + 1, uec_pkg::uec_dir_t'(i[0]), 11'h008 + i, uec_pkg::uec_ep_type_t'(i),
                2'h3 - i[1:0], i[2:0] + 3'h1);
        cfgw(2'h0, uec_pkg::dir_sel_in_side, 11'h008, uec_pkg::ep_type_isochronous, 2'h1, 3'h7);
        chk("ep0_fixed", cfg_rd_mps, `UEC_EP0_MPS);
        for (int i = 0; i < 4; i++)
        begin
            cfg_ep = i / 2 + 1;
            cfg_dir = uec_pkg::uec_dir_t'(i[0]);
            tick(1);
            chk("rd_mps", cfg_rd_mps, 11'h008 + i);
            chk("rd_type", cfg_rd_type, i[1:0]);
            chk("rd_dma", cfg_rd_dma, 2'h3 - i[1:0]);
            chk("rd_auto", cfg_rd_auto, i[2:0] + 3'h1);
        end
    endtask : t_cfg
    task automatic t_stall;
        u_host.token(7'h2b, 2'h1, uec_pkg::dir_sel_in_side);
        chk("miss", tok_hit, 1'b0);
        u_host.token(7'h2a, 2'h1, uec_pkg::dir_sel_in_side);
        chk("hit", tok_hit, 1'b1);
        cmd_ep = 2'h1;
        cmd_dir = uec_pkg::dir_sel_in_side;
        pulse(stall_set);
        stall_tok(uec_pkg::dir_sel_in_side, 1'b1);
        stall_tok(uec_pkg::dir_sel_out_side, 1'b0);
        stall_tok(uec_pkg::dir_sel_in_side, 1'b1);
        cmd_dir = uec_pkg::dir_sel_out_side;
        pulse(stall_set);
        stall_tok(uec_pkg::dir_sel_out_side, 1'b1);
        pulse(stall_clr);
        stall_tok(uec_pkg::dir_sel_in_side, 1'b1);
        stall_tok(uec_pkg::dir_sel_out_side, 1'b0);
        cmd_dir = uec_pkg::dir_sel_in_side;
        pulse(stall_clr);
        stall_tok(uec_pkg::dir_sel_in_side, 1'b0);
    endtask : t_stall
    task automatic t_rx;
        cfgw(2'h1, uec_pkg::dir_sel_out_side, 11'h008, uec_pkg::ep_type_bulk, 2'h0, 3'h0);
        u_host.packet(7'h2a, 2'h1, 3, 8'h10);
        chk("count", rx_byte_count, 11'd3);
        pop(3, 8'h10);
        chk("count0", rx_byte_count, 11'd0);
        chk("rdy_kept", out_status, 5'h11);
        status_clr_bits = 5'h10;
        pulse(status_clr);
        chk("clr_exact", out_status, 5'h01);
        status_clr_bits = out_status;
        pulse(status_clr);
        chk("clr_read", out_status, 5'h00);
        u_host.packet(7'h2a, 2'h1, 2, 8'h20);
        pop(2, 8'h20);
        final_packet_flag = 1'b1;
        pulse(data_ack);
        chk("ack_clr", out_status[4], 1'b0);
        chk("end_ep1", ep0_data_end, 1'b0);
        cmd_ep = 2'h0;
        data_ack = 1'b1;
        tick(1);
        data_ack = 1'b0;
        chk("end_ep0", ep0_data_end, 1'b1);
        tick(1);
        chk("end_once", ep0_data_end, 1'b0);
        cmd_ep = 2'h1;
    endtask : t_rx
    task automatic t_auto;
        cfgw(2'h1, uec_pkg::dir_sel_out_side, 11'h004, uec_pkg::ep_type_bulk, 2'h0, 3'h3);
        chk("req_empty", rx_more_request, 1'b1);
        u_host.packet(7'h2a, 2'h1, 8, 8'h40);
        chk("full_cnt", rx_byte_count, 11'd8);
        chk("refuse", rx_byte_ready, 1'b0);
        chk("full_bit", out_status[3], 1'b1);
        chk("req_full", rx_more_request, 1'b0);
        pop(3, 8'h40);
        chk("req_3free", rx_more_request, 1'b0);
        pop(1, 8'h43);
        chk("req_4free", rx_more_request, 1'b1);
        pop(4, 8'h44);
        chk("auto_clr", out_status[4], 1'b0);
        chk("cnt_empty", rx_byte_count, 11'd0);
    endtask : t_auto
    task automatic t_tx;
        cfgw(2'h1, uec_pkg::dir_sel_in_side, 11'h004, uec_pkg::ep_type_interrupt, 2'h0, 3'h4);
        repeat (3) pulse(tx_byte_wr);
        chk("tx_short", tx_pkt_ready, 1'b0);
        pulse(tx_byte_wr);
        chk("tx_full", tx_pkt_ready, 1'b1);
        u_host.token(7'h2a, 2'h1, uec_pkg::dir_sel_in_side);
        chk("tx_ack", tok_hs, uec_pkg::hs_ack);
        chk("tx_taken", tx_pkt_ready, 1'b0);
    endtask : t_tx
    // --------
    // Main
    // --------
    initial
    begin
        #100us;
        n_errors++;
        finish_test();
    end
    initial
    begin
        {rst_n, dual_role_device_select, soft_connect, addr_wr, cfg_wr, stall_set} = 6'h00;
        {stall_clr, status_clr, data_ack, final_packet_flag, tx_byte_wr, rd_ready} = 6'h00;
        {tx_auto_send, rx_auto_request, rx_auto_ready_clear} = 3'h0;
        {addr_wdata, cfg_ep, cmd_ep, ep_dma_access_select, max_packet_bytes} = 24'h000000;
        cfg_dir = uec_pkg::dir_sel_out_side;
        cmd_dir = uec_pkg::dir_sel_out_side;
        cfg_type = uec_pkg::ep_type_bulk;
        status_clr_bits = 5'h00;
        tick(4);
        rst_n = 1'b1;
        t_mode();
        t_cfg();
        t_stall();
        t_rx();
        t_auto();
        t_tx();
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
